// *** logic_array.sv ***
// Top of the programmable lookup logic array: config store, element fabric,
// state flops and output selection. Assumes one clock; the logic clock pin and
// primary inputs arrive asynchronously and are synchronised here.
`timescale 1ns/1ps
`include "plu_defs.svh"

// Function
// - 26 elements, 32-bit table, 32:1 mux
// - Each element input picks pin, element, flop
// - Four state flops capture element outputs
// - Flops advance only on logic clock edges
// - Reset clears all state flops
// - Eight outputs each pick element or flop
// - Network runs without configuration activity
// - Six-bit selector, 36 valid sources
// - All-ones selector gives constant zero
// - Configuration stored on bus clock
// - Six primary inputs reach every element input selector
module logic_array (
   input wire logic clk,                              // Bus clock, 100 MHz
   input wire logic rst_n,                            // Chip reset, active low
   input wire logic cfg_load,                         // Pulse: capture cfg_in
   input wire plu_pkg::cfg_t cfg_in,                  // Tables and selectors
   input wire logic [`LA_NUM_IN-1:0] plu_in,          // Primary input pins
   input wire logic logic_clk,                        // External logic clock pin
   output logic [`LA_NUM_OUT-1:0] plu_out,            // Primary outputs
   output logic [`LA_NUM_OUT-1:0] outputs_status      // Bus-side view of outputs
);

   plu_pkg::cfg_t cfg;
   logic [`LA_NUM_IN-1:0] in_s1;
   logic [`LA_NUM_IN-1:0] in_s2;
   logic lclk_s1;
   logic lclk_s2;
   logic lclk_s3;
   logic lclk_rise;
   logic [`LA_NUM_FF-1:0] state_ff;
   logic [`LA_NUM_LUT-1:0] lut_out;
   logic [`LA_NUM_SRC-1:0] src;
   logic [`LA_NUM_OUT-1:0] next_out;

   function automatic plu_pkg::cfg_t cfg_reset();
      plu_pkg::cfg_t c;
      for (int n = 0; n < `LA_NUM_LUT; n++) begin
         for (int k = 0; k < `LA_NUM_LUT_IN; k++) begin
            c.inp_sel[n][k] = `LA_SEL_NONE;
         end
         c.truth[n] = `LA_TRUTH_RST;
      end
      for (int o = 0; o < `LA_NUM_OUT; o++) begin
         c.out_sel[o] = `LA_OSEL_NONE;
      end
      return c;
   endfunction

   // Output selector decode, shared by all eight outputs
   function automatic logic out_pick(input plu_pkg::out_sel_t code, input logic [`LA_NUM_LUT-1:0] l,
                                     input logic [`LA_NUM_FF-1:0] f);
      logic r;
      r = 1'b0;
      if (code == `LA_OSEL_NONE) begin
         r = 1'b0;
      end else if (code < `LA_OSEL_FF_BASE) begin
         r = l[code];
      end else if (code < `LA_OSEL_FF_BASE + 5'(`LA_NUM_FF)) begin
         r = f[2'(code - `LA_OSEL_FF_BASE)];
      end
      return r;
   endfunction

   // Configuration only changes on reset or an explicit load, never by itself
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cfg <= cfg_reset();
      end else if (cfg_load) begin
         cfg <= cfg_in;
      end
   end

   // Pins are asynchronous to clk
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         in_s1 <= '0;
         in_s2 <= '0;
      end else begin
         in_s1 <= plu_in;
         in_s2 <= in_s1;
      end
   end

   // Logic clock is sampled, so it must stay below a quarter of clk
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         lclk_s1 <= 1'b0;
         lclk_s2 <= 1'b0;
         lclk_s3 <= 1'b0;
      end else begin
         lclk_s1 <= logic_clk;
         lclk_s2 <= lclk_s1;
         lclk_s3 <= lclk_s2;
      end
   end

   assign lclk_rise = lclk_s2 & ~lclk_s3;

   assign src = {state_ff, lut_out, in_s2};

   genvar n;
   generate
      for (n = 0; n < `LA_NUM_LUT; n++) begin : g_lut
         lut_cell #(
            .SELF(n)
         ) u_lut (
            .sel(cfg.inp_sel[n]),
            .truth(cfg.truth[n]),
            .src(src),
            .lut_out(lut_out[n])
         );
      end
   endgenerate

   // Flop k holds element k; no logic clock edge means no state change
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_ff <= '0;
      end else if (lclk_rise) begin
         state_ff <= lut_out[`LA_NUM_FF-1:0];
      end
   end

   genvar o;
   generate
      for (o = 0; o < `LA_NUM_OUT; o++) begin : g_out
         assign next_out[o] = out_pick(cfg.out_sel[o], lut_out, state_ff);
      end
   endgenerate

   // Outputs keep running with cfg_load idle
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         plu_out <= '0;
      end else begin
         plu_out <= next_out;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         outputs_status <= '0;
      end else begin
         outputs_status <= plu_out;
      end
   end

endmodule // logic_array

// *** plu_defs.svh ***
// Constants for the programmable lookup logic array.
// Assumes inclusion by the package, the top module and the element module only.
`ifndef PLU_DEFS_SVH
`define PLU_DEFS_SVH

`define LA_NUM_LUT 26
`define LA_NUM_LUT_IN 5
`define LA_NUM_IN 6
`define LA_NUM_FF 4
`define LA_NUM_OUT 8
`define LA_TRUTH_W 32
`define LA_SEL_W 6
`define LA_OSEL_W 5
`define LA_NUM_SRC 36
`define LA_SRC_LUT_BASE 6'h06
`define LA_SRC_FF_BASE 6'h20
`define LA_SEL_NONE 6'h3F
`define LA_OSEL_NONE 5'h1F
`define LA_OSEL_FF_BASE 5'h1A
`define LA_TRUTH_RST 32'h0000_0000
`define LA_LUT_IDX_W 5

`endif

// *** plu_pkg.sv ***
// Types for the programmable lookup logic array.
// Assumes plu_defs.svh is on the include path.
`include "plu_defs.svh"

package plu_pkg;

   typedef logic [`LA_SEL_W-1:0] lut_sel_t;
   typedef logic [`LA_OSEL_W-1:0] out_sel_t;
   typedef lut_sel_t [`LA_NUM_LUT_IN-1:0] lut_sels_t;

   typedef struct packed {
      lut_sels_t [`LA_NUM_LUT-1:0] inp_sel;
      logic [`LA_NUM_LUT-1:0][`LA_TRUTH_W-1:0] truth;
      out_sel_t [`LA_NUM_OUT-1:0] out_sel;
   } cfg_t;

endpackage

// *** lut_cell.sv ***
// One five-input lookup element with its own input selectors.
// Assumes a flat source vector: pins, then element outputs, then state flops.
`timescale 1ns/1ps
`include "plu_defs.svh"

module lut_cell #(
   parameter int SELF = 0
) (
   input wire plu_pkg::lut_sels_t sel,              // Five input selector codes
   input wire logic [`LA_TRUTH_W-1:0] truth,        // Truth table
   input wire logic [`LA_NUM_SRC-1:0] src,          // All selectable sources
   output logic lut_out                             // Element output
);

   logic [`LA_NUM_LUT_IN-1:0] lut_in;

   // Own output and out-of-range codes give zero; selecting self would close a loop
   function automatic logic pick(input plu_pkg::lut_sel_t code, input logic [`LA_NUM_SRC-1:0] s);
      logic r;
      r = 1'b0;
      if (code == `LA_SEL_NONE) begin
         r = 1'b0;
      end else if (code == `LA_SRC_LUT_BASE + 6'(SELF)) begin
         r = 1'b0;
      end else if (code < 6'(`LA_NUM_SRC)) begin
         r = s[code];
      end
      return r;
   endfunction

   genvar i;
   generate
      for (i = 0; i < `LA_NUM_LUT_IN; i++) begin : g_in
         assign lut_in[i] = pick(sel[i], src);
      end
   endgenerate

   assign lut_out = truth[lut_in];

endmodule // lut_cell

// *** logic_array_checker.sv ***
// Port-level checks for logic_array.
// Assumes a bind onto logic_array.
`timescale 1ns/1ps
module logic_array_checker (
   input wire logic clk, // Bus clock
   input wire logic rst_n, // Reset
   input wire logic cfg_load, // Config strobe
   input wire logic [5:0] plu_in, // Pins
   input wire logic logic_clk, // Logic clock
   input wire logic [7:0] plu_out, // Outputs
   input wire logic [7:0] outputs_status // Status
);
   logic [3:0] quiet;
   logic loaded;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // Cycles since any pin or config activity
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) quiet <= 4'h0;
      else if (cfg_load || $changed(plu_in) || $changed(logic_clk)) quiet <= 4'h0;
      else if (quiet != 4'hF) quiet <= quiet + 4'h1;
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) loaded <= 1'b0;
      else if (cfg_load) loaded <= 1'b1;
   end
   a_rst_out: assert property (disable iff (1'b0) !rst_n |-> plu_out == 8'h00) else $error("out set");
   a_rst_stat: assert property (disable iff (1'b0) !rst_n |-> outputs_status == 8'h00) else $error("st set");
   a_first_edge: assert property ($rose(rst_n) |-> plu_out == 8'h00) else $error("out early");
   a_stat_rise: assert property ($rose(rst_n) |=> outputs_status == 8'h00) else $error("st early");
   a_stat_copy: assert property (1'b1 |=> outputs_status == $past(plu_out)) else $error("st lag");
   a_out_quiet: assert property (quiet >= 4'h6 |-> $stable(plu_out)) else $error("out moved");
   a_stat_quiet: assert property (quiet >= 4'h7 |-> $stable(outputs_status)) else $error("st moved");
   a_cfg_none: assert property (!loaded |-> plu_out == 8'h00) else $error("out unset");
   c_out_move: cover property ($changed(plu_out));
   c_flop_out: cover property (plu_out[6]);
   c_rerun: cover property ($rose(rst_n) ##[1:50] loaded);
endmodule // logic_array_checker

bind logic_array logic_array_checker logic_array_checker_i (.clk(clk), .rst_n(rst_n), .cfg_load(cfg_load),
   .plu_in(plu_in), .logic_clk(logic_clk), .plu_out(plu_out), .outputs_status(outputs_status));

// *** pin_model.sv ***
// Pin side: primary inputs and logic clock.
// Assumes the bench paces it through apply.
`timescale 1ns/1ps
module pin_model (
   input wire logic clk, // Pacing clock
   output logic [5:0] plu_in, // Inputs
   output logic logic_clk // Idles low
);
   initial begin
      plu_in = 6'h00;
      logic_clk = 1'b0;
   end
   task automatic apply(input logic [5:0] v, input logic tick);
      @(posedge clk) #1 plu_in = v;
      repeat (3) @(posedge clk);
      // Inputs held across the edge
      if (tick) begin
         #1 logic_clk = 1'b1;
         repeat (3) @(posedge clk);
         #1 logic_clk = 1'b0;
         repeat (3) @(posedge clk);
      end
   endtask
endmodule // pin_model

// *** logic_array_test.sv ***
// Bench: parity, gate and flop network.
// Assumes plu_pkg and the checker compiled.
`timescale 1ns/1ps
module logic_array_test;
   typedef struct packed {
      logic [5:0] in;
      logic tick;
      logic [7:0] out;
   } row_t;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic cfg_load = 1'b0;
   plu_pkg::cfg_t cfg_in;
   logic [5:0] plu_in;
   logic logic_clk;
   logic [7:0] plu_out;
   logic [7:0] outputs_status;
   int n_fail = 0;
   int total_checks = 0;
   row_t rows [7] = '{'{6'h00, 1'b0, 8'h24}, '{6'h01, 1'b0, 8'h25}, '{6'h21, 1'b0, 8'h27},
      '{6'h21, 1'b1, 8'h57}, '{6'h1F, 1'b1, 8'h15}, '{6'h03, 1'b1, 8'h24}, '{6'h03, 1'b1, 8'h64}};
   logic_array logic_array_i (.clk(clk), .rst_n(rst_n), .cfg_load(cfg_load), .cfg_in(cfg_in),
      .plu_in(plu_in), .logic_clk(logic_clk), .plu_out(plu_out), .outputs_status(outputs_status));
   pin_model pin_model_i (.clk(clk), .plu_in(plu_in), .logic_clk(logic_clk));
   initial begin
      forever #5 clk = ~clk;
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask
   task automatic finish_test();
      $display("checks %0d fails %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic load();
      @(posedge clk) #1 cfg_load = 1'b1;
      @(posedge clk) #1 cfg_load = 1'b0;
   endtask
   task automatic step(input row_t r);
      pin_model_i.apply(r.in, r.tick);
      repeat (4) @(posedge clk);
      #2 chk(plu_out, r.out);
      @(posedge clk);
      #2 chk(outputs_status, r.out);
   endtask
   initial begin
      cfg_in = '0;
      cfg_in.inp_sel = '1;
      cfg_in.out_sel = '1;
      repeat (6) @(posedge clk);
      #1 chk(plu_out, 8'h00);
      rst_n = 1'b1;
      for (int k = 0; k < 5; k++) cfg_in.inp_sel[0][k] = 6'(k);
      cfg_in.truth[0] = 32'h9669_6996;
      cfg_in.inp_sel[1][0] = 6'h05;
      cfg_in.inp_sel[1][1] = 6'h06;
      cfg_in.truth[1] = 32'h0000_0008;
      cfg_in.truth[2] = 32'h0000_0001;
      cfg_in.inp_sel[3][0] = 6'h20;
      cfg_in.truth[3] = 32'h0000_0001;
      // Self select must read as zero
      cfg_in.inp_sel[4][0] = 6'h0A;
      cfg_in.truth[4] = 32'h0000_0002;
      cfg_in.out_sel = {5'h04, 5'h1D, 5'h03, 5'h1A, 5'h1F, 5'h02, 5'h01, 5'h00};
      load();
      foreach (rows[i]) begin
         step(rows[i]);
         $display("row %0d done", i);
      end
      // Flop 3 is set here; reset must drop it
      @(posedge clk) #1 rst_n = 1'b0;
      @(posedge clk) #1 chk(outputs_status, 8'h00);
      chk(plu_out, 8'h00);
      rst_n = 1'b1;
      // Out-of-range source and unused output code must both read as zero
      cfg_in.inp_sel[4][0] = 6'h24;
      cfg_in.out_sel[3] = 5'h1E;
      load();
      step('{6'h03, 1'b0, 8'h24});
      $display("reset done");
      finish_test();
   end
   initial begin
      #100000;
      n_fail++;
      finish_test();
   end
endmodule // logic_array_test
